// ===== core/ldp_consts.vh
// constants for the l1 data prefetch engine
`ifndef LDP_CONSTS_VH
`define LDP_CONSTS_VH
// hint kinds on the pipeline side
`define LDP_HINT_LOAD 2'h0
`define LDP_HINT_STORE 2'h1
`define LDP_HINT_NT 2'h2
// fill state of a requested line
`define LDP_FILL_SHARED 1'h0
`define LDP_FILL_MODIFIED 1'h1
// line geometry and stream defaults
`define LDP_ADDR_W 48
`define LDP_LINE_OFS_W 6
`define LDP_STREAMS 4
`define LDP_INIT_COUNT 3
`define LDP_MAX_DIST 8
`define LDP_CNT_W 4
// engine states
`define LDP_ST_IDLE 2'h0
`define LDP_ST_BURST 2'h1
`endif

// ===== core/ldp_prefetch_engine.v
// l1 data prefetch engine: software hints and unit-stride hw prefetcher
`include "ldp_consts.vh"
module ldp_prefetch_engine #(
   parameter ADDR_W = `LDP_ADDR_W,
   parameter STREAMS = `LDP_STREAMS,
   parameter INIT_COUNT = `LDP_INIT_COUNT,
   parameter MAX_DIST = `LDP_MAX_DIST
) (
   // clock and reset
   input wire core_clk_in,
   input wire reset_n_in,
   // software hints from the load-store pipeline
   input wire hint_valid_in,
   input wire [1:0] hint_kind_in,
   input wire [ADDR_W-1:0] hint_addr_in,
   input wire emulation_control_bit_in,
   input wire task_switched_control_bit_in,
   // demand accesses
   input wire acc_valid_in,
   input wire acc_miss_in,
   input wire [ADDR_W-1:0] acc_addr_in,
   // fill completions and l1 lookup
   input wire fill_done_in,
   input wire l1_present_in,
   input wire l1_pending_in,
   output reg [ADDR_W-`LDP_LINE_OFS_W-1:0] probe_line_out,
   // read requests to the hierarchy
   input wire rd_ready_in,
   output reg rd_valid_out,
   output reg [ADDR_W-1:0] rd_addr_out,
   output reg rd_fill_modified_out,
   output reg rd_l1_only_out,
   output reg rd_nt_out,
   output reg reg_write_out
);
   localparam LINE_W = ADDR_W - `LDP_LINE_OFS_W;
   localparam CW = `LDP_CNT_W;

   // ************************************************************
   // software hint path
   // ************************************************************
   // control bits deliberately unused: hints never fault or stall
   wire ctl_ignored_w = emulation_control_bit_in & task_switched_control_bit_in & 1'b0;
   wire [LINE_W-1:0] hint_line_w = hint_addr_in[ADDR_W-1:`LDP_LINE_OFS_W];
   wire hint_st_w = hint_valid_in & ~ctl_ignored_w;
   wire hint_mod_w = (hint_kind_in == `LDP_HINT_STORE);
   wire hint_nt_w = (hint_kind_in == `LDP_HINT_NT);
   // software hints also act as training accesses in cycles with no demand access
   wire tr_valid_w = acc_valid_in | hint_st_w;
   wire tr_miss_w = acc_valid_in ? acc_miss_in : ~(l1_present_in | l1_pending_in);
   wire [LINE_W-1:0] tr_line_w = acc_valid_in ? acc_addr_in[ADDR_W-1:`LDP_LINE_OFS_W]
                                              : hint_line_w;
   wire tr_nt_w = ~acc_valid_in & hint_nt_w;

   // ************************************************************
   // stream table
   // ************************************************************
   reg [LINE_W-1:0] last_miss_q;
   reg last_miss_v_q;
   reg last_miss_nt_q;
   reg [STREAMS-1:0] s_v_q;
   reg [STREAMS-1:0] s_nt_q;
   reg [LINE_W-1:0] s_next_q [0:STREAMS-1];  // next expected demand line
   reg [LINE_W-1:0] s_front_q [0:STREAMS-1]; // next line to prefetch
   reg [CW-1:0] s_pend_q [0:STREAMS-1];
   reg [CW-1:0] s_dist_q [0:STREAMS-1];
   reg [1:0] victim_q;

   // hit on a stream: index of first matching entry
   reg hit_w;
   reg [1:0] hit_idx_w;
   integer k;
   always @* begin
      hit_w = 1'b0;
      hit_idx_w = 2'h0;
      for (k = STREAMS - 1; k >= 0; k = k - 1) begin
         if (s_v_q[k] && s_next_q[k] == tr_line_w) begin
            hit_w = 1'b1;
            hit_idx_w = k[1:0];
         end
      end
   end

   wire train_open_w = tr_valid_w & tr_miss_w & ~hit_w & last_miss_v_q
                       & (tr_line_w == last_miss_q + 1'b1);

   // hardware issue: first stream with outstanding budget
   integer m;
   reg hw_v_w;
   reg [1:0] hw_idx_w;
   always @* begin
      hw_v_w = 1'b0;
      hw_idx_w = 2'h0;
      for (m = STREAMS - 1; m >= 0; m = m - 1) begin
         if (s_v_q[m] && s_pend_q[m] != {CW{1'b0}}) begin
            hw_v_w = 1'b1;
            hw_idx_w = m[1:0];
         end
      end
   end
   wire hw_taken_w;
   // output stage frees when empty or accepted; the arbiter slot waits on it
   wire out_free_w = ~(rd_valid_out & ~rd_ready_in);

   // ************************************************************
   // arbiter and filter
   // ************************************************************
   wire [LINE_W-1:0] probe_w;
   wire arb_v_w;
   wire [LINE_W-1:0] arb_line_w;
   wire arb_mod_w;
   wire arb_nt_w;
   ldp_req_arb #(.LINE_W(LINE_W)) u_arb (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .sw_valid_in(hint_st_w),
      .sw_line_in(hint_line_w),
      .sw_modified_in(hint_mod_w),
      .sw_nt_in(hint_nt_w),
      .hw_valid_in(hw_v_w),
      .hw_line_in(s_front_q[hw_idx_w]),
      .hw_nt_in(s_nt_q[hw_idx_w]),
      .hw_taken_out(hw_taken_w),
      .l1_present_in(l1_present_in),
      .l1_pending_in(l1_pending_in),
      .probe_line_out(probe_w),
      .rd_ready_in(out_free_w),
      .rd_valid_out(arb_v_w),
      .rd_line_out(arb_line_w),
      .rd_modified_out(arb_mod_w),
      .rd_nt_out(arb_nt_w)
   );

   // ************************************************************
   // stream update
   // ************************************************************
   integer i;
   always @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         last_miss_q <= {LINE_W{1'b0}};
         last_miss_v_q <= 1'b0;
         last_miss_nt_q <= 1'b0;
         s_v_q <= {STREAMS{1'b0}};
         s_nt_q <= {STREAMS{1'b0}};
         victim_q <= 2'h0;
         for (i = 0; i < STREAMS; i = i + 1) begin
            s_next_q[i] <= {LINE_W{1'b0}};
            s_front_q[i] <= {LINE_W{1'b0}};
            s_pend_q[i] <= {CW{1'b0}};
            s_dist_q[i] <= {CW{1'b0}};
         end
      end else begin
         // only misses that open nothing are remembered for training
         if (tr_valid_w && tr_miss_w && !hit_w) begin
            last_miss_q <= tr_line_w;
            last_miss_v_q <= 1'b1;
            last_miss_nt_q <= tr_nt_w;
         end
         // budget consumed when the arbiter takes a hw line
         if (hw_taken_w) begin
            s_front_q[hw_idx_w] <= s_front_q[hw_idx_w] + 1'b1;
            s_pend_q[hw_idx_w] <= s_pend_q[hw_idx_w] - 1'b1;
         end
         if (train_open_w) begin
            s_v_q[victim_q] <= 1'b1;
            s_nt_q[victim_q] <= last_miss_nt_q | tr_nt_w;
            s_next_q[victim_q] <= tr_line_w + 1'b1;
            s_front_q[victim_q] <= tr_line_w + 1'b1;
            s_pend_q[victim_q] <= INIT_COUNT[CW-1:0];
            s_dist_q[victim_q] <= INIT_COUNT[CW-1:0];
            victim_q <= victim_q + 1'b1;
            last_miss_v_q <= 1'b0;
         end else if (tr_valid_w && hit_w) begin
            s_next_q[hit_idx_w] <= tr_line_w + 1'b1;
            // miss on expected line means demand caught the prefetches
            if (tr_miss_w && s_dist_q[hit_idx_w] < MAX_DIST[CW-1:0]) begin
               s_dist_q[hit_idx_w] <= s_dist_q[hit_idx_w] + 1'b1;
               s_pend_q[hit_idx_w] <= s_pend_q[hit_idx_w] + 2'h2
                  - {{(CW-1){1'b0}}, (hw_taken_w && hw_idx_w == hit_idx_w)};
            end else begin
               s_pend_q[hit_idx_w] <= s_pend_q[hit_idx_w] + 1'b1
                  - {{(CW-1){1'b0}}, (hw_taken_w && hw_idx_w == hit_idx_w)};
            end
         end
      end
   end

   // ************************************************************
   // registered outputs
   // ************************************************************
   // the fill/eviction policy rides along with each read
   always @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         rd_valid_out <= 1'b0;
         rd_addr_out <= {ADDR_W{1'b0}};
         rd_fill_modified_out <= `LDP_FILL_SHARED;
         rd_l1_only_out <= 1'b0;
         rd_nt_out <= 1'b0;
         reg_write_out <= 1'b0;
         probe_line_out <= {LINE_W{1'b0}};
      end else begin
         // a stalled read holds whole so no hw prefetch is lost; a hint arriving while the arbiter slot is stalled is dropped
         if (out_free_w) begin
            rd_valid_out <= arb_v_w;
            rd_addr_out <= {arb_line_w, {`LDP_LINE_OFS_W{1'b0}}};
            rd_fill_modified_out <= arb_mod_w;
            // NT: hierarchy skips L2 writeback unless line came from L2
            rd_nt_out <= arb_nt_w;
         end
         rd_l1_only_out <= 1'b1;
         reg_write_out <= 1'b0 & fill_done_in;
         probe_line_out <= probe_w;
      end
   end
endmodule // ldp_prefetch_engine

// ===== core/ldp_req_arb.v
// two-source request arbiter with an l1 present/pending filter
`include "ldp_consts.vh"
module ldp_req_arb #(
   parameter LINE_W = 42
) (
   // clock and reset
   input wire core_clk_in,
   input wire reset_n_in,
   // software request (higher priority)
   input wire sw_valid_in,
   input wire [LINE_W-1:0] sw_line_in,
   input wire sw_modified_in,
   input wire sw_nt_in,
   // hardware request
   input wire hw_valid_in,
   input wire [LINE_W-1:0] hw_line_in,
   input wire hw_nt_in,
   output wire hw_taken_out,
   // cache lookup of the candidate line
   input wire l1_present_in,
   input wire l1_pending_in,
   output wire [LINE_W-1:0] probe_line_out,
   // memory read side
   input wire rd_ready_in,
   output reg rd_valid_out,
   output reg [LINE_W-1:0] rd_line_out,
   output reg rd_modified_out,
   output reg rd_nt_out
);
   // ************************************************************
   // selection
   // ************************************************************
   wire busy_w = rd_valid_out & ~rd_ready_in;
   wire pick_hw_w = ~sw_valid_in & hw_valid_in;
   wire any_w = sw_valid_in | hw_valid_in;
   assign probe_line_out = sw_valid_in ? sw_line_in : hw_line_in;
   // filtered requests are still consumed so the stream moves on
   assign hw_taken_out = pick_hw_w & ~busy_w;
   wire drop_w = l1_present_in | l1_pending_in;

   // output slot holds until the hierarchy accepts it
   always @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         rd_valid_out <= 1'b0;
         rd_line_out <= {LINE_W{1'b0}};
         rd_modified_out <= 1'b0;
         rd_nt_out <= 1'b0;
      end else if (!busy_w) begin
         rd_valid_out <= any_w & ~drop_w;
         rd_line_out <= probe_line_out;
         rd_modified_out <= sw_valid_in & sw_modified_in;
         rd_nt_out <= sw_valid_in ? sw_nt_in : (pick_hw_w & hw_nt_in);
      end
   end
endmodule // ldp_req_arb

// ===== verification/ldp_hier_model.sv
// far-side cache hierarchy model: read acceptance and l1 lookup
module ldp_hier_model (
   // clock and reset
   input logic core_clk_in,
   input logic reset_n_in,
   // scenario controls
   input logic slow_in,
   input logic present_in,
   // engine side
   output logic rd_ready_out,
   output logic l1_present_out,
   output logic l1_pending_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tog_q;
   // slow mode accepts every other cycle so the read slot stalls
   always @(posedge core_clk_in) tog_q <= reset_n_in ? ~tog_q : 1'b0;
   assign rd_ready_out = !slow_in || tog_q;
   assign l1_present_out = present_in;
   assign l1_pending_out = 1'b0;
endmodule // ldp_hier_model

// ===== verification/ldp_monitor.sv
// checker watching the prefetch engine ports
`include "ldp_consts.vh"
module ldp_monitor #(
   parameter ADDR_W = 48
) (
   // clock and reset
   input logic core_clk_in,
   input logic reset_n_in,
   // hints and accesses
   input logic hint_valid_in,
   input logic [1:0] hint_kind_in,
   input logic [ADDR_W-1:0] hint_addr_in,
   input logic acc_valid_in,
   input logic acc_miss_in,
   input logic [ADDR_W-1:0] acc_addr_in,
   // lookup and read side
   input logic l1_present_in,
   input logic l1_pending_in,
   input logic rd_ready_in,
   input logic rd_valid_out,
   input logic [ADDR_W-1:0] rd_addr_out,
   input logic rd_fill_modified_out,
   input logic rd_l1_only_out,
   input logic rd_nt_out,
   input logic reg_write_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   // hint taken with a free slot, its line absent from l1
   sequence s_hint;
      hint_valid_in && rd_ready_in && !rd_valid_out && !l1_present_in && !l1_pending_in
      ##1 rd_ready_in;
   endsequence
   // two fresh adjacent misses; earlier streams may hide the burst
   property p_open;
      logic [ADDR_W-7:0] ln;
      !(acc_valid_in && acc_miss_in) ##1
      (acc_valid_in && acc_miss_in && !hint_valid_in, ln = acc_addr_in[ADDR_W-1:6]) ##1
      (acc_valid_in && acc_miss_in && !hint_valid_in && acc_addr_in[ADDR_W-1:6] == ln + 1)
      |-> ##[1:12] (rd_valid_out && rd_ready_in && rd_addr_out[ADDR_W-1:6] == ln + 2);
   endproperty
   a_hint_issue: assert property (s_hint |=> rd_valid_out &&
      rd_addr_out[ADDR_W-1:6] == $past(hint_addr_in[ADDR_W-1:6], 2)) else $error("hint lost");
   a_store_mod: assert property (s_hint |=>
      rd_fill_modified_out == ($past(hint_kind_in, 2) == `LDP_HINT_STORE)) else $error("fill state");
   a_nt_hint: assert property (s_hint |=>
      rd_nt_out == ($past(hint_kind_in, 2) == `LDP_HINT_NT)) else $error("nt flag");
   a_line_align: assert property (rd_valid_out |-> rd_addr_out[5:0] == 6'h00)
      else $error("unaligned read");
   a_fill_l1: assert property (rd_valid_out |-> rd_l1_only_out)
      else $error("not an l1 fill");
   a_no_regwr: assert property (!reg_write_out)
      else $error("register write");
   a_stream_open: assert property (p_open)
      else $error("no burst");
   a_stall_hold: assert property (rd_valid_out && !rd_ready_in |=> rd_valid_out
      && $stable(rd_addr_out)) else $error("stalled read changed");
   c_store: cover property (rd_valid_out && rd_fill_modified_out);
   c_nt: cover property (rd_valid_out && rd_nt_out);
   c_stall: cover property (rd_valid_out && !rd_ready_in);
endmodule // ldp_monitor
bind ldp_prefetch_engine ldp_monitor #(.ADDR_W(ADDR_W)) mon_u (.*);

// ===== verification/testbench.sv
// self-checking bench for the prefetch engine
`include "ldp_consts.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in, reset_n_in, hint_valid_in, emulation_control_bit_in;
   logic task_switched_control_bit_in, acc_valid_in, acc_miss_in, fill_done_in;
   logic l1_present_in, l1_pending_in, rd_ready_in, rd_valid_out, rd_fill_modified_out;
   logic rd_l1_only_out, rd_nt_out, reg_write_out, slow, present;
   logic [1:0] hint_kind_in;
   logic [47:0] hint_addr_in, acc_addr_in, rd_addr_out;
   logic [41:0] probe_line_out;
   logic [49:0] rq[$];
   int n_fail, checks_done;
   ldp_prefetch_engine dut_u (.*);
   ldp_hier_model far_u (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .slow_in(slow), .present_in(present), .rd_ready_out(rd_ready_in),
      .l1_present_out(l1_present_in), .l1_pending_out(l1_pending_in));
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   // accepted reads as {nt, modified, address}
   always @(posedge core_clk_in) if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1) begin
      rq.push_back({rd_nt_out, rd_fill_modified_out, rd_addr_out});
   end
   task chk(input logic [63:0] g, input logic [63:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // inputs move 1 ns after the edge; idle cycles drop both strobes
   task step(input int n);
      hint_valid_in = 1'b0;
      acc_valid_in = 1'b0;
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   // strobe stays up until the next step, so back-to-back calls never toggle it
   task hint(input logic [1:0] k, input logic [47:0] a);
      hint_kind_in = k;
      hint_addr_in = a;
      hint_valid_in = 1'b1;
      @(posedge core_clk_in);
      #1;
   endtask
   task acc(input logic m, input logic [47:0] a);
      acc_valid_in = 1'b1;
      acc_miss_in = m;
      acc_addr_in = a;
      @(posedge core_clk_in);
      #1;
   endtask
   // each kind once, control bits flipped, unaligned address
   task t_hints;
      logic [47:0] a;
      for (int k = 0; k < 3; k++) begin
         a = (48'h4000 << k) | 48'h3d;
         rq.delete();
         emulation_control_bit_in = k[0];
         task_switched_control_bit_in = ~k[0];
         hint(k[1:0], a);
         chk(probe_line_out, a[47:6]);
         step(8);
         chk(rq.size(), 1);
         chk(rq[0], {k == 2, k == 1, a[47:6], 6'h00});
      end
   endtask
   // line already in l1 gives no read
   task t_present;
      rq.delete();
      present = 1'b1;
      hint(`LDP_HINT_LOAD, 48'h9000);
      step(8);
      present = 1'b0;
      chk(rq.size(), 0);
   endtask
   // stalled hierarchy: burst of three, then one per next-line hit
   task t_stream;
      rq.delete();
      slow = 1'b1;
      acc(1'b1, 48'h100008);
      acc(1'b1, 48'h100048);
      step(30);
      chk(rq.size(), 3);
      for (int i = 0; i < 3; i++) chk(rq[i], 48'h100080 + 48'h40 * i);
      rq.delete();
      acc(1'b0, 48'h100090);
      step(20);
      slow = 1'b0;
      chk(rq.size(), 1);
      chk(rq[0], 48'h100140);
      // miss on the expected line: distance grows, two more lines
      rq.delete();
      acc(1'b1, 48'h1000c0);
      step(20);
      chk(rq.size(), 2);
      chk(rq[0], 48'h100180);
      chk(rq[1], 48'h1001c0);
   endtask
   // nt hints to adjacent lines train a tagged stream
   task t_nt_stream;
      rq.delete();
      hint(`LDP_HINT_NT, 48'h200000);
      hint(`LDP_HINT_NT, 48'h200040);
      step(20);
      chk(rq.size(), 5);
      foreach (rq[i]) chk(rq[i][49], 1'b1);
   endtask
   initial begin
      {reset_n_in, acc_miss_in, fill_done_in} = 3'h0;
      {emulation_control_bit_in, task_switched_control_bit_in, slow, present} = 4'h0;
      hint_kind_in = 2'h0;
      hint_addr_in = 48'h0;
      acc_addr_in = 48'h0;
      step(16);
      reset_n_in = 1'b1;
      step(2);
      t_hints();
      t_present();
      t_stream();
      t_nt_stream();
      stop_test();
   end
   // the tests need about 150 cycles
   initial begin
      #20us;
      n_fail++;
      stop_test();
   end
endmodule // testbench
